// file: flash_protect_defines.svh
// Constants for the flash rewrite-protection control block.
// Assumes a 32-bit APB slave port; register byte address is four times the index.
`ifndef FLASH_PROTECT_DEFINES_SVH
`define FLASH_PROTECT_DEFINES_SVH

`define IDX_MAIN_CONTROL 10'h1b4
`define IDX_PROTECT_CONTROL 10'h1b5
`define MAIN_RESET 8'h00
`define PROTECT_RESET 8'h00
`define ENABLE_BIT 1
`define STOP_BIT 3
`define ABORT_BIT 4
`define BYPASS_BIT 3
`define INHIBIT_LSB 4
`define INHIBIT_MSB 7
`define READ_ZERO_32 32'h0000_0000

`endif

// file: flash_protect_pkg.sv
// Types shared by the flash rewrite-protection block.
// Assumes the command sequencer runs on the same clock as the APB.
`default_nettype none
package flash_protect_pkg;

	// Command presented by the sequencer for an acceptance decision
	typedef struct packed {
		logic valid;
		logic erase;
		logic data_flash;
		logic [1:0] block;
	} cmd_req_t;

	// Completion and exception events from the sequencer, one-cycle pulses
	typedef struct packed {
		logic program_done;
		logic erase_done;
		logic seq_error;
		logic suspend_enter;
		logic [1:0] erase_block;
	} seq_event_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WAIT = 3'b010,
		ST_DONE = 3'b100
	} apb_state_t;

endpackage
`default_nettype wire

// file: flash_rewrite_protect_control.sv
// Flash rewrite-protection control: lock bypass, data-flash block inhibits and the
// rewrite enable / stop / abort bits, behind an APB slave.
// Assumes sequencer inputs are synchronous to pclk and event inputs are one-cycle pulses.
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "flash_protect_defines.svh"

module flash_rewrite_protect_control #(
	parameter bit REDUCED_VARIANT = 1'b0
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire flash_protect_pkg::cmd_req_t cmd_req,
	input wire flash_protect_pkg::seq_event_t seq_event,
	output logic cmd_accept,
	output logic cmd_refused,
	output logic lock_bypass_select,
	output logic [3:0] block_rewrite_inhibit,
	output logic cpu_rewrite_enable,
	output logic flash_stop,
	output logic sequence_abort,
	output logic lock_release,
	output logic [1:0] lock_release_block
);

	// ****************************************************************
	// APB handshake
	// ****************************************************************
	flash_protect_pkg::apb_state_t state;
	logic access_done;
	logic wr_done;
	logic hit_main;
	logic hit_prot;

	assign hit_main = paddr[11:2] == `IDX_MAIN_CONTROL;
	assign hit_prot = paddr[11:2] == `IDX_PROTECT_CONTROL;
	assign access_done = psel & penable & pready;
	assign wr_done = access_done & pwrite;

	// One wait state: pready rises in the second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= flash_protect_pkg::ST_IDLE;
		end else begin
			unique case (state)
				flash_protect_pkg::ST_IDLE: begin
					if (psel & penable)
						state <= flash_protect_pkg::ST_WAIT;
				end
				flash_protect_pkg::ST_WAIT: begin
					state <= flash_protect_pkg::ST_DONE;
				end
				flash_protect_pkg::ST_DONE: begin
					state <= flash_protect_pkg::ST_IDLE;
				end
				default: begin
					state <= flash_protect_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= (state == flash_protect_pkg::ST_IDLE) & psel & penable;
		end
	end

	// ****************************************************************
	// Write-pair arming
	// ****************************************************************
	// A protected transition needs the opposite value written by the previous
	// transfer; any intervening transfer, even to another address, disarms it.
	logic prot_wr;
	logic main_wr;
	logic arm_bypass;
	logic arm_enable;
	logic [3:0] arm_inhibit;

	assign prot_wr = wr_done & hit_prot;
	assign main_wr = wr_done & hit_main;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			arm_bypass <= 1'b0;
			arm_enable <= 1'b0;
			arm_inhibit <= 4'h0;
		end else if (access_done) begin
			arm_bypass <= prot_wr & ~pwdata[`BYPASS_BIT];
			arm_enable <= main_wr & ~pwdata[`ENABLE_BIT];
			arm_inhibit <= {4{prot_wr}} & pwdata[`INHIBIT_MSB:`INHIBIT_LSB];
		end
	end

	// ****************************************************************
	// Main control: rewrite enable, stop, abort
	// ****************************************************************
	logic disable_wr;
	logic stop_set_wr;
	logic abort_wr;

	assign disable_wr = main_wr & ~pwdata[`ENABLE_BIT];
	// Stop and abort act only while rewriting is enabled
	assign stop_set_wr = main_wr & pwdata[`STOP_BIT] & cpu_rewrite_enable;
	assign abort_wr = main_wr & pwdata[`ABORT_BIT] & cpu_rewrite_enable;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_rewrite_enable <= 1'(`MAIN_RESET >> `ENABLE_BIT);
			flash_stop <= 1'(`MAIN_RESET >> `STOP_BIT);
		end else if (main_wr) begin
			cpu_rewrite_enable <= pwdata[`ENABLE_BIT] & (arm_enable | cpu_rewrite_enable);
			if (cpu_rewrite_enable)
				flash_stop <= pwdata[`STOP_BIT];
		end
	end

	// Abort is a pulse; the bit itself always reads as zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sequence_abort <= 1'b0;
		end else begin
			sequence_abort <= abort_wr;
		end
	end

	// ****************************************************************
	// Lock bypass select
	// ****************************************************************
	logic bypass_clear;

	assign bypass_clear = seq_event.program_done | seq_event.erase_done
		| seq_event.seq_error | seq_event.suspend_enter
		| disable_wr | stop_set_wr | abort_wr;

	// Hardware clears win over a software set in the same cycle, so a set can
	// never survive the end of the operation it was meant for.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_bypass_select <= 1'(`PROTECT_RESET >> `BYPASS_BIT);
		end else if (bypass_clear) begin
			lock_bypass_select <= 1'b0;
		end else if (prot_wr) begin
			// Only this software path ever sets the bit
			lock_bypass_select <= pwdata[`BYPASS_BIT] & (arm_bypass | lock_bypass_select);
		end
	end

	// ****************************************************************
	// Data-flash block inhibits
	// ****************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_inhibit
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					block_rewrite_inhibit[gi] <= 1'b0;
				end else if (REDUCED_VARIANT || disable_wr) begin
					block_rewrite_inhibit[gi] <= 1'b0;
				end else if (prot_wr) begin
					// Setting is free; clearing needs a 1 written just before
					block_rewrite_inhibit[gi] <= pwdata[`INHIBIT_LSB + gi]
						| (block_rewrite_inhibit[gi] & ~arm_inhibit[gi]);
				end
			end
		end
	endgenerate

	// ****************************************************************
	// Command acceptance and lock release
	// ****************************************************************
	logic blocked;

	assign blocked = cmd_req.data_flash & block_rewrite_inhibit[cmd_req.block];

	// A refusal raises no error; the sequencer just sees cmd_refused
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_accept <= 1'b0;
			cmd_refused <= 1'b0;
		end else begin
			cmd_accept <= cmd_req.valid & cpu_rewrite_enable & ~flash_stop & ~blocked;
			cmd_refused <= cmd_req.valid & ~(cpu_rewrite_enable & ~flash_stop & ~blocked);
		end
	end

	// Lock bits live in the flash array; this only requests an unlock there.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_release <= 1'b0;
			lock_release_block <= 2'h0;
		end else begin
			lock_release <= seq_event.erase_done & lock_bypass_select;
			if (seq_event.erase_done)
				lock_release_block <= seq_event.erase_block;
		end
	end

	// ****************************************************************
	// Read data
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= `READ_ZERO_32;
			pslverr <= 1'b0;
		end else if ((state == flash_protect_pkg::ST_IDLE) & psel & penable) begin
			prdata <= `READ_ZERO_32;
			pslverr <= ~(hit_main | hit_prot);
			if (hit_prot & ~pwrite)
				prdata[`INHIBIT_MSB:`BYPASS_BIT] <= {block_rewrite_inhibit, lock_bypass_select};
			if (hit_main & ~pwrite) begin
				prdata[`ENABLE_BIT] <= cpu_rewrite_enable;
				prdata[`STOP_BIT] <= flash_stop;
			end
		end else begin
			pslverr <= 1'b0;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_set_write;
		prot_wr & pwdata[`BYPASS_BIT] & ~bypass_clear;
	endsequence

	a_bypass_pair: assert property (
		s_set_write ##0 (~arm_bypass & ~lock_bypass_select) |=> ~lock_bypass_select)
		else $error("bypass set without preceding zero write");

	a_bypass_set_ok: assert property (
		s_set_write ##0 arm_bypass |=> lock_bypass_select)
		else $error("armed bypass set ignored");

	a_inhibit_pair: assert property (
		(prot_wr & ~pwdata[`INHIBIT_LSB] & ~arm_inhibit[0] & block_rewrite_inhibit[0]
			& ~disable_wr) |=> block_rewrite_inhibit[0])
		else $error("inhibit cleared without preceding one write");

	a_disable_clears: assert property (
		disable_wr |=> (block_rewrite_inhibit == 4'h0) && !lock_bypass_select)
		else $error("rewrite disable left protection bits set");

	a_refuse_inhibit: assert property (
		(cmd_req.valid & blocked) |=> cmd_refused & !cmd_accept)
		else $error("inhibited block command not refused");

	a_accept_clear: assert property (
		(cmd_req.valid & cpu_rewrite_enable & ~flash_stop & ~blocked) |=> cmd_accept)
		else $error("enabled command not accepted");

	a_events_clear: assert property (
		(seq_event.program_done | seq_event.erase_done | seq_event.seq_error
			| seq_event.suspend_enter)
			|=> !lock_bypass_select)
		else $error("bypass survived completion event");

	a_abort_clear: assert property (
		abort_wr |=> (!lock_bypass_select && sequence_abort) ##1 !sequence_abort)
		else $error("abort did not clear bypass");

	a_no_hw_set: assert property (
		$rose(lock_bypass_select) |-> $past(prot_wr))
		else $error("bypass set without software write");

	a_lock_release: assert property (
		(seq_event.erase_done & lock_bypass_select)
			|=> lock_release && lock_release_block == $past(seq_event.erase_block))
		else $error("erase under bypass did not release lock");

	a_disabled_refuse: assert property (
		(cmd_req.valid & ~cpu_rewrite_enable) |=> cmd_refused)
		else $error("command accepted while rewrite disabled");

	a_reserved_zero: assert property (
		((state == flash_protect_pkg::ST_IDLE) & psel & penable & hit_prot & ~pwrite)
			|=> prdata[2:0] == 3'h0 ##0 pready)
		else $error("reserved bits read nonzero");

	a_reduced_zero: assert property (
		REDUCED_VARIANT |-> (block_rewrite_inhibit == 4'h0) [*2])
		else $error("reduced variant inhibit set");

	a_stop_clear: assert property (
		stop_set_wr |=> !lock_bypass_select && flash_stop)
		else $error("flash stop did not clear bypass");

	// Enable needs a 0 written by the transfer just before
	a_enable_pair: assert property (
		(main_wr & pwdata[`ENABLE_BIT] & ~arm_enable & ~cpu_rewrite_enable)
			|=> !cpu_rewrite_enable)
		else $error("rewrite enabled without preceding zero write");

endmodule
`default_nettype wire

// file: flash_rewrite_protect_control_tb.sv
// Self-checking bench for the flash rewrite-protection control block.
// Assumes the APB slave answers after two access cycles and sequencer pulses are registered.
`timescale 1ns/1ps
`default_nettype none
`include "flash_protect_defines.svh"
module flash_rewrite_protect_control_tb;
	localparam logic [11:0] MAIN = {`IDX_MAIN_CONTROL, 2'b00};
	localparam logic [11:0] PROT = {`IDX_PROTECT_CONTROL, 2'b00};
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	flash_protect_pkg::cmd_req_t cmd_req;
	flash_protect_pkg::seq_event_t seq_event;
	logic cmd_accept, cmd_refused, lock_bypass_select, cpu_rewrite_enable, flash_stop;
	logic sequence_abort, lock_release;
	logic [3:0] block_rewrite_inhibit, mask;
	logic [1:0] lock_release_block;
	logic r_accept, r_refused;
	logic [3:0] r_inhibit;
	int fails = 0;
	int checks_done = 0;
	int cycles = 0;
	int seed;

	flash_rewrite_protect_control i_flash_rewrite_protect_control (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cmd_req(cmd_req), .seq_event(seq_event), .cmd_accept(cmd_accept),
		.cmd_refused(cmd_refused), .lock_bypass_select(lock_bypass_select),
		.block_rewrite_inhibit(block_rewrite_inhibit), .cpu_rewrite_enable(cpu_rewrite_enable),
		.flash_stop(flash_stop), .sequence_abort(sequence_abort), .lock_release(lock_release),
		.lock_release_block(lock_release_block));

	// Reduced variant on the same stimulus; only its inhibits and command answers are watched
	flash_rewrite_protect_control #(.REDUCED_VARIANT(1'b1)) i_flash_rewrite_protect_control_reduced (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
		.cmd_req(cmd_req), .seq_event(seq_event), .cmd_accept(r_accept),
		.cmd_refused(r_refused), .lock_bypass_select(), .block_rewrite_inhibit(r_inhibit),
		.cpu_rewrite_enable(), .flash_stop(), .sequence_abort(), .lock_release(),
		.lock_release_block());

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	// ***********************
	// Shared tasks
	// ***********************
	task automatic close_out();
		$display("Checks %0d, mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Cuts a hang short; the whole run needs well under this many cycles
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails++;
			close_out();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	// One APB transfer; outputs are looked at after the falling edge that follows
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Ends when pready is seen high; only the bench timeout ends a wait that never sees it
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge pclk);
	endtask

	task automatic cmd(input logic er, input logic df, input logic [1:0] b, input logic ok,
		input logic rok);
		@(posedge pclk);
		cmd_req <= '{valid: 1'b1, erase: er, data_flash: df, block: b};
		@(posedge pclk);
		cmd_req <= '0;
		@(negedge pclk);
		check({cmd_accept, cmd_refused}, {ok, !ok}, "command answer");
		check({r_accept, r_refused}, {rok, !rok}, "reduced answer");
	endtask

	task automatic set_bypass();
		apb(1'b1, PROT, 32'h0000_0000);
		apb(1'b1, PROT, 32'h0000_000f);
		check(lock_bypass_select, 1'b1, "bypass pair");
	endtask

	task automatic pulse(input int k, input logic [1:0] b);
		flash_protect_pkg::seq_event_t e;
		e = {4'b1000 >> k, b};
		@(posedge pclk);
		seq_event <= e;
		@(posedge pclk);
		seq_event <= '0;
		@(negedge pclk);
		check(lock_bypass_select, 1'b0, "bypass after event");
		check(lock_release, k == 1, "lock release");
		if (k == 1) check(lock_release_block, b, "release block");
	endtask

	function automatic logic exp_ok(input logic df, input logic [1:0] b, input logic [3:0] m);
		return !(df && m[b]);
	endfunction

	// ***********************
	// Main sequence
	// ***********************
	initial begin
		seed = 34011;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		cmd_req = '0;
		seq_event = '0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, PROT, 32'h0000_0000);
		check(rd, 32'h0000_0000, "protect reset");
		apb(1'b0, 12'h000, 32'h0000_0000);
		check(err, 1'b1, "unmapped error");
		cmd(1'b0, 1'b0, 2'd0, 1'b0, 1'b0);
		$display("reset and refusal test done");
		apb(1'b1, MAIN, 32'h0000_0000);
		apb(1'b1, MAIN, 32'h0000_0002);
		apb(1'b1, PROT, 32'h0000_0008);
		check(lock_bypass_select, 1'b0, "unpaired bypass set");
		set_bypass();
		apb(1'b0, PROT, 32'h0000_0000);
		check(rd, 32'h0000_0008, "bypass readback");
		for (int k = 0; k < 4; k++) begin
			set_bypass();
			pulse(k, 2'($random(seed)));
		end
		$display("bypass event test done");
		for (int it = 0; it < 8; it++) begin
			mask = 4'($random(seed));
			apb(1'b1, PROT, {24'h0, mask, 4'h0});
			apb(1'b0, PROT, 32'h0000_0000);
			check(rd, {24'h0, mask, 4'h0}, "inhibit readback");
			check(r_inhibit, 4'h0, "reduced inhibit");
			for (int b = 0; b < 4; b++) begin
				cmd(1'($random(seed)), 1'b1, 2'(b), exp_ok(1'b1, 2'(b), mask), 1'b1);
			end
			cmd(1'b1, 1'b0, 2'($random(seed)), 1'b1, 1'b1);
			apb(1'b1, PROT, 32'h0000_0000);
			check(block_rewrite_inhibit, mask, "unpaired inhibit clear");
			apb(1'b1, PROT, {24'h0, mask, 4'h0});
			apb(1'b1, PROT, 32'h0000_0000);
			check(block_rewrite_inhibit, 4'h0, "paired inhibit clear");
		end
		$display("inhibit test done");
		set_bypass();
		apb(1'b1, MAIN, 32'h0000_0012);
		check(lock_bypass_select, 1'b0, "bypass after abort");
		check(sequence_abort, 1'b1, "abort pulse");
		apb(1'b0, MAIN, 32'h0000_0000);
		check(rd, 32'h0000_0002, "abort reads zero");
		set_bypass();
		apb(1'b1, MAIN, 32'h0000_000a);
		check(lock_bypass_select, 1'b0, "bypass after stop");
		cmd(1'b0, 1'b0, 2'd1, 1'b0, 1'b0);
		apb(1'b1, MAIN, 32'h0000_0002);
		check(flash_stop, 1'b0, "stop cleared");
		set_bypass();
		apb(1'b1, PROT, 32'h0000_00f8);
		check({lock_bypass_select, block_rewrite_inhibit}, 5'h1f, "bypass and inhibits set");
		apb(1'b1, MAIN, 32'h0000_0000);
		check({lock_bypass_select, block_rewrite_inhibit}, 5'h00, "disable clears");
		check(cpu_rewrite_enable, 1'b0, "rewrite disabled");
		cmd(1'b1, 1'b1, 2'd2, 1'b0, 1'b0);
		$display("stop abort disable test done");
		apb(1'b1, MAIN, 32'h0000_0002);
		check(cpu_rewrite_enable, 1'b1, "enable pair");
		apb(1'b1, PROT, 32'h0000_00f0);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		check({cpu_rewrite_enable, block_rewrite_inhibit}, 5'h00, "mid-run reset");
		apb(1'b0, PROT, 32'h0000_0000);
		check(rd, 32'h0000_0000, "protect after reset");
		apb(1'b1, MAIN, 32'h0000_0002);
		check(cpu_rewrite_enable, 1'b0, "unpaired enable");
		cmd(1'b0, 1'b1, 2'd0, 1'b0, 1'b0);
		$display("reset and enable test done");
		close_out();
	end
endmodule
`default_nettype wire
